// >>> shared/eits_params.svh
// constants for the external interrupt and trap source block
// assumes pclk equals the high clock; low clock ticks arrive as a strobe
`ifndef EITS_PARAMS_SVH
`define EITS_PARAMS_SVH

// register byte offsets
`define EITS_OFS_CONTROL    8'h00
`define EITS_OFS_ENABLE     8'h04
`define EITS_OFS_SRCSEL     8'h08
`define EITS_OFS_LATCH      8'h0C
`define EITS_OFS_WATCHDOG   8'h10
`define EITS_OFS_STACKPTR   8'h14
`define EITS_OFS_MODE       8'h18

// control register fields
`define EITS_CTL_ONE_EDGE   0
`define EITS_CTL_TWO_EDGE   1
`define EITS_CTL_THREE_EDGE 2
`define EITS_CTL_FOUR_LO    3
`define EITS_CTL_FOUR_HI    4
`define EITS_CTL_PIN_SEL    6
`define EITS_CTL_FILT_SEL   7
`define EITS_CTL_RESET      8'h00

// enable register fields
`define EITS_EN_MASTER      0
`define EITS_EN_FLAG4       4
`define EITS_EN_FLAG5       5
`define EITS_EN_FLAG8       8
`define EITS_EN_FLAG11      11
`define EITS_EN_FLAG14      14
`define EITS_EN_FLAG15      15
`define EITS_EN_RESET       16'h0000

// source select, watchdog, mode fields
`define EITS_SRC_LEVEL14    0
`define EITS_SRC_LEVEL15    1
`define EITS_WDT_TRAP_IRQ   0
`define EITS_MODE_SLOW      0

// four edge modes
`define EITS_FOUR_RISE      2'h0
`define EITS_FOUR_FALL      2'h1
`define EITS_FOUR_BOTH      2'h2
`define EITS_FOUR_HIGH      2'h3

// acceptance times in high clock periods
`define EITS_ACC_SHORT_FC   7
`define EITS_ACC_ONE_A_FC   49
`define EITS_ACC_ONE_B_FC   193
`define EITS_ACC_MID_FC     25
// acceptance time in low clock ticks
`define EITS_ACC_SLOW_FS    3
// one high clock period per pclk at 125 MHz
`define EITS_FC_PER_PCLK    1

// stack handling
`define EITS_SP_RESET       8'hFF
`define EITS_SP_STEP        8'h03
`define EITS_SP_ONE         8'h01
`define EITS_SP_TWO         8'h02
`define EITS_SOFT_OPCODE    8'hFF
`define EITS_IMF_BIT        0

// fetch region map
`define EITS_SFR_BASE       16'h0000
`define EITS_SFR_END        16'h003F
`define EITS_DBR_BASE       16'h0F80
`define EITS_DBR_END        16'h0FFF
`define EITS_RAM_BASE       16'h0040
`define EITS_RAM_END        16'h023F

`define EITS_NUM_EXT        6
`endif

// >>> shared/eits_pkg.sv
// types shared by the interrupt source block and its bench
// assumes eits_params.svh supplies all numeric constants
package eits_pkg;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        exists;
    logic        undefined;
  } eits_fetch_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] pc;
    logic [7:0]  status_word;
  } eits_return_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] pc;
    logic [7:0]  status_word;
  } eits_accept_t;

endpackage

// >>> rtl/eits_core.sv
// external interrupt inputs, trap detection and interrupt stack handling
// assumes a cpu core drives fetch, accept and return strobes on pclk
`timescale 1ns/1ps
`include "eits_params.svh"

// Behaviour
// RULE1: return pops pc and status with master enable; sp plus 3.
// RULE2: after acceptance pc low at sp+1, high at sp+2.
// RULE3: unaltered nonmaskable return traps again.
// RULE4: requests sampled in each instruction's last cycle.
// RULE5: software skipping return adds 3 to sp.
// RULE6: soft opcode starts top priority soft interrupt at once.
// RULE7: missing address fetch in single chip reads FF, soft interrupt.
// RULE8: fetch from ram, data buffer or function region traps.
// RULE9: trap gives reset or trap interrupt per watchdog bit.
// RULE10: undefined opcode interrupts, even in nonmaskable service.
// RULE11: address trap accepted at once, even in nonmaskable service.
// RULE12: six external inputs, each noise filtered.
// RULE13: pin zero is port or interrupt input, port after reset.
// RULE14: input zero: master, flag 4, pin select; falling; accept 7.
// RULE15: input one: master, flag 5; chosen edge; accept 49 or 193.
// RULE16: inputs two, three: flags 8, 11; chosen edge; accept 25.
// RULE17: input four: flag 14, select 0; four edge modes; accept 25.
// RULE18: input five: flag 15, select 0; falling; accept 7.
// RULE19: slow mode filters use low clock, accept after three ticks.
// RULE20: clean edge sets latch within filter time plus six low clocks.
// RULE21: pin select zero keeps pin zero edges off its latch.
// RULE22: software disables flags while driving shared pins.
// RULE23: input one filter select change acts within 26 high clocks.
// RULE24: input four level mode needs a rising edge after reset.
// RULE25: source select picks input four or serial transmit.
// RULE26: each pin passes a two flip-flop synchroniser first.
// RULE27: filter counter restarts on change, passes level once stable.
module eits_core #(
  parameter int CNT_W = 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [5:0]           ext_pin,
  input  wire logic                 low_clock_tick,
  input  wire logic                 serial_tx_irq,
  input  wire logic                 adc_irq,
  input  wire logic [5:0]           latch_ack,
  input  wire logic                 single_chip,
  input  wire logic                 instr_last_cycle,
  input  wire eits_pkg::eits_fetch_t  fetch,
  input  wire eits_pkg::eits_accept_t accept,
  input  wire logic                 maskable_return_op,
  input  wire logic                 nonmaskable_return_op,
  output eits_pkg::eits_return_t    ret,
  output logic [7:0]                fetch_opcode,
  output logic                      irq_request,
  output logic                      soft_irq,
  output logic                      undefined_op_irq,
  output logic                      addr_trap_irq,
  output logic                      trap_reset_out,
  output logic                      port_zero_bit_zero,
  output logic                      master_irq_enable
);

  logic [7:0]  ext_irq_control;
  logic [15:0] enable_flags;
  logic [1:0]  source_select;
  logic        watchdog_control;
  logic        slow_mode;
  logic [7:0]  stack_ptr;
  logic [5:0]  irq_latch;
  logic [7:0]  stack_mem [0:255];

  logic [5:0]  sync_a;
  logic [5:0]  sync_b;
  logic [5:0]  filt;
  logic [5:0]  filt_prev;
  logic [5:0]  primed;
  logic        four_armed;
  logic [1:0]  sync_fill;
  logic [CNT_W-1:0] filt_cnt [0:5];

  // acceptance count less one, in ticks of the active filter clock
  function automatic logic [CNT_W-1:0] accept_count(input int ch, input logic long_sel, input logic slow);
    int n;
    n = `EITS_ACC_SHORT_FC * `EITS_FC_PER_PCLK;
    if (slow)
      n = `EITS_ACC_SLOW_FS;
    else if (ch == 1)
      n = (long_sel ? `EITS_ACC_ONE_B_FC : `EITS_ACC_ONE_A_FC) * `EITS_FC_PER_PCLK;
    else if (ch >= 2 && ch <= 4)
      n = `EITS_ACC_MID_FC * `EITS_FC_PER_PCLK;
    return CNT_W'(n - 1);
  endfunction

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // apb decode
  wire setup_ph  = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_en     = access_ph && pwrite;
  wire hit_ctl   = paddr == `EITS_OFS_CONTROL;
  wire hit_en    = paddr == `EITS_OFS_ENABLE;
  wire hit_src   = paddr == `EITS_OFS_SRCSEL;
  wire hit_lat   = paddr == `EITS_OFS_LATCH;
  wire hit_wdt   = paddr == `EITS_OFS_WATCHDOG;
  wire hit_sp    = paddr == `EITS_OFS_STACKPTR;
  wire hit_mode  = paddr == `EITS_OFS_MODE;
  wire hit_any   = hit_ctl || hit_en || hit_src || hit_lat || hit_wdt || hit_sp || hit_mode;

  logic [31:0] read_word;
  always_comb
  begin
    read_word = 32'h0000_0000;
    if (hit_ctl)
      read_word = {24'h00_0000, ext_irq_control};
    else if (hit_en)
      read_word = {16'h0000, enable_flags[15:1], master_irq_enable};
    else if (hit_src)
      read_word = {30'h0000_0000, source_select};
    else if (hit_lat)
      read_word = {16'h0000, 2'h0, filt, 2'h0, irq_latch};
    else if (hit_wdt)
      read_word = {31'h0000_0000, watchdog_control};
    else if (hit_sp)
      read_word = {24'h00_0000, stack_ptr};
    else if (hit_mode)
      read_word = {31'h0000_0000, slow_mode};
  end

  assign pready  = 1'b1;
  assign pslverr = access_ph && !hit_any;

  // read data taken in setup, so it leaves a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_ph)
      prdata <= read_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_irq_control  <= `EITS_CTL_RESET; // [RULE13]
      enable_flags     <= `EITS_EN_RESET;
      source_select    <= 2'h0;
      watchdog_control <= 1'b0;
      slow_mode        <= 1'b0;
    end
    else if (wr_en)
    begin
      if (hit_ctl)
        ext_irq_control <= pwdata[7:0];
      if (hit_en)
        enable_flags <= {pwdata[15:1], 1'b0};
      if (hit_src)
        source_select <= pwdata[1:0];
      if (hit_wdt)
        watchdog_control <= pwdata[`EITS_WDT_TRAP_IRQ];
      if (hit_mode)
        slow_mode <= pwdata[`EITS_MODE_SLOW];
    end
  end

  // stack addresses around the pointer
  wire [7:0] sp_p1 = stack_ptr + `EITS_SP_ONE;
  wire [7:0] sp_p2 = stack_ptr + `EITS_SP_TWO;
  wire [7:0] sp_p3 = stack_ptr + `EITS_SP_STEP;
  wire [7:0] sp_m1 = stack_ptr - `EITS_SP_ONE;
  wire [7:0] sp_m2 = stack_ptr - `EITS_SP_TWO;
  wire [7:0] sp_m3 = stack_ptr - `EITS_SP_STEP;
  wire       any_return = maskable_return_op || nonmaskable_return_op;

  // push order status, high, low leaves low at sp+1 and high at sp+2
  always_ff @(posedge pclk)
  begin
    if (accept.valid)
    begin
      stack_mem[stack_ptr] <= {accept.status_word[7:1], master_irq_enable};
      stack_mem[sp_m1]     <= accept.pc[15:8]; // [RULE2]
      stack_mem[sp_m2]     <= accept.pc[7:0]; // [RULE2]
    end
  end

  // accept and return outrank a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stack_ptr         <= `EITS_SP_RESET;
      master_irq_enable <= 1'b0;
      ret               <= '0;
    end
    else
    begin
      ret.valid <= 1'b0;
      if (accept.valid)
      begin
        stack_ptr         <= sp_m3;
        master_irq_enable <= 1'b0;
      end
      else if (any_return)
      begin
        stack_ptr         <= sp_p3; // [RULE1]
        master_irq_enable <= stack_mem[sp_p3][`EITS_IMF_BIT]; // [RULE1]
        ret.valid         <= 1'b1;
        // untouched trap return address traps again [RULE3]
        ret.pc            <= {stack_mem[sp_p2], stack_mem[sp_p1]}; // [RULE1]
        ret.status_word   <= stack_mem[sp_p3]; // [RULE1]
      end
      else if (wr_en && hit_sp)
        stack_ptr <= pwdata[7:0]; // [RULE5]
      else if (wr_en && hit_en)
        master_irq_enable <= pwdata[`EITS_EN_MASTER];
    end
  end

  // fetch checks
  wire [7:0] eff_opcode = (single_chip && !fetch.exists) ? `EITS_SOFT_OPCODE : fetch.data; // [RULE7]
  wire is_soft  = fetch.valid && eff_opcode == `EITS_SOFT_OPCODE; // [RULE6]
  wire is_undef = fetch.valid && fetch.undefined && !is_soft; // [RULE10]
  wire in_trap  = in_range(fetch.addr, `EITS_SFR_BASE, `EITS_SFR_END) ||
                  in_range(fetch.addr, `EITS_DBR_BASE, `EITS_DBR_END) ||
                  in_range(fetch.addr, `EITS_RAM_BASE, `EITS_RAM_END);
  wire is_trap  = fetch.valid && in_trap; // [RULE8]

  // nonmaskable sources ignore master enable and service
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_opcode     <= 8'h00;
      soft_irq         <= 1'b0;
      undefined_op_irq <= 1'b0;
      addr_trap_irq    <= 1'b0;
      trap_reset_out   <= 1'b0;
    end
    else
    begin
      fetch_opcode     <= eff_opcode; // [RULE7]
      soft_irq         <= is_soft && !is_trap; // [RULE6]
      undefined_op_irq <= is_undef && !is_trap; // [RULE10]
      addr_trap_irq    <= is_trap && watchdog_control; // [RULE9] [RULE11]
      trap_reset_out   <= is_trap && !watchdog_control; // [RULE9]
    end
  end

  // synchroniser, first stage read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
      sync_fill <= 2'h0;
    end
    else
    begin
      sync_fill <= {sync_fill[0], 1'b1};
      sync_a <= ext_pin; // [RULE26]
      sync_b <= sync_a; // [RULE26]
    end
  end

  wire filt_tick = slow_mode ? low_clock_tick : 1'b1; // [RULE19]

  // threshold read live, so a select change acts at once
  genvar gi;
  generate
    for (gi = 0; gi < `EITS_NUM_EXT; gi++)
    begin : g_filt
      wire [CNT_W-1:0] thr = accept_count(gi, ext_irq_control[`EITS_CTL_FILT_SEL], slow_mode); // [RULE23]
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          filt_cnt[gi]  <= '0;
          filt[gi]      <= 1'b0;
          filt_prev[gi] <= 1'b0;
          primed[gi]    <= 1'b0;
        end
        else
        begin
          filt_prev[gi] <= filt[gi];
          if (sync_b[gi] == filt[gi])
          begin
            filt_cnt[gi] <= '0; // [RULE27]
            if (filt_tick && sync_fill[1])
              primed[gi] <= 1'b1;
          end
          else if (filt_tick)
          begin
            if (filt_cnt[gi] >= thr)
            begin
              filt[gi]     <= sync_b[gi]; // [RULE12] [RULE27]
              filt_cnt[gi] <= '0;
            end
            else
              filt_cnt[gi] <= filt_cnt[gi] + CNT_W'(1);
          end
        end
      end
    end
  endgenerate

  // first settled level after reset is no edge
  wire [5:0] rise = filt & ~filt_prev & primed;
  wire [5:0] fall = ~filt & filt_prev & primed;
  wire [1:0] four_mode = ext_irq_control[`EITS_CTL_FOUR_HI:`EITS_CTL_FOUR_LO];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      four_armed <= 1'b0;
    else if (rise[4])
      four_armed <= 1'b1; // [RULE24]
  end

  wire four_event = (four_mode == `EITS_FOUR_RISE) ? rise[4] :
                    (four_mode == `EITS_FOUR_FALL) ? fall[4] :
                    (four_mode == `EITS_FOUR_BOTH) ? (rise[4] || fall[4]) :
                    (filt[4] && four_armed); // [RULE17] [RULE24]

  wire pin_sel = ext_irq_control[`EITS_CTL_PIN_SEL];
  wire [5:0] set_ev;
  assign set_ev[0] = fall[0] && pin_sel; // [RULE14] [RULE21]
  assign set_ev[1] = ext_irq_control[`EITS_CTL_ONE_EDGE] ? fall[1] : rise[1]; // [RULE15]
  assign set_ev[2] = ext_irq_control[`EITS_CTL_TWO_EDGE] ? fall[2] : rise[2]; // [RULE16]
  assign set_ev[3] = ext_irq_control[`EITS_CTL_THREE_EDGE] ? fall[3] : rise[3]; // [RULE16]
  assign set_ev[4] = source_select[`EITS_SRC_LEVEL14] ? serial_tx_irq : four_event; // [RULE25]
  assign set_ev[5] = source_select[`EITS_SRC_LEVEL15] ? adc_irq : fall[5]; // [RULE18]

  wire [5:0] sw_clear = (wr_en && hit_lat) ? pwdata[5:0] : 6'h00;

  // set wins over acknowledge and clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_latch <= 6'h00;
    else
      irq_latch <= (irq_latch & ~(latch_ack | sw_clear)) | set_ev; // [RULE20]
  end

  wire [5:0] ef_mask = {enable_flags[`EITS_EN_FLAG15], enable_flags[`EITS_EN_FLAG14],
                        enable_flags[`EITS_EN_FLAG11], enable_flags[`EITS_EN_FLAG8],
                        enable_flags[`EITS_EN_FLAG5], enable_flags[`EITS_EN_FLAG4] && pin_sel}; // [RULE14]
  wire pending = master_irq_enable && |(irq_latch & ef_mask); // [RULE15] [RULE16] [RULE17] [RULE18]

  // sampled at last cycle only, so a return chains straight in
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_request <= 1'b0;
    else if (instr_last_cycle)
      irq_request <= pending; // [RULE4]
  end

  // pin zero port read works in either pin function
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_zero_bit_zero <= 1'b0;
    else
      port_zero_bit_zero <= sync_b[0]; // [RULE13]
  end

endmodule

// >>> verif/eits_core_sva.sv
// concurrent checks on the ports of the interrupt source block
// assumes one pclk domain with presetn as its asynchronous reset
`timescale 1ns/1ps
`include "eits_params.svh"
module eits_core_sva (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   single_chip,
  input wire logic                   instr_last_cycle,
  input wire eits_pkg::eits_fetch_t  fetch,
  input wire eits_pkg::eits_accept_t accept,
  input wire logic                   maskable_return_op,
  input wire logic                   nonmaskable_return_op,
  input wire eits_pkg::eits_return_t ret,
  input wire logic [7:0]             fetch_opcode,
  input wire logic                   irq_request,
  input wire logic                   soft_irq,
  input wire logic                   undefined_op_irq,
  input wire logic                   addr_trap_irq,
  input wire logic                   trap_reset_out,
  input wire logic                   master_irq_enable
);
  wire trap_hit = (fetch.addr <= `EITS_RAM_END) || (fetch.addr >= `EITS_DBR_BASE && fetch.addr <= `EITS_DBR_END);
  wire ret_op   = maskable_return_op | nonmaskable_return_op;
  wire missing  = single_chip & ~fetch.exists;
  wire soft_hit = missing | (fetch.data == `EITS_SOFT_OPCODE);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ret_pulse_a: assert property (ret_op && !accept.valid |=> ret.valid ##1 !ret.valid)
    else $error("no return pulse");
  ret_master_a: assert property (ret.valid |-> master_irq_enable == ret.status_word[`EITS_IMF_BIT])
    else $error("master not restored");
  trap_hit_a: assert property (fetch.valid && trap_hit |=> addr_trap_irq != trap_reset_out)
    else $error("trap action missing");
  trap_miss_a: assert property (fetch.valid && !trap_hit |=> !addr_trap_irq && !trap_reset_out)
    else $error("stray trap action");
  soft_op_a: assert property (fetch.valid && !trap_hit && soft_hit |=> soft_irq && !undefined_op_irq)
    else $error("soft opcode missed");
  addr_err_a: assert property (fetch.valid && missing |=> fetch_opcode == `EITS_SOFT_OPCODE)
    else $error("missing address not FF");
  undef_op_a: assert property (fetch.valid && !trap_hit && !soft_hit && fetch.undefined |=> undefined_op_irq)
    else $error("undefined opcode missed");
  no_event_a: assert property (!fetch.valid |=> !soft_irq && !undefined_op_irq && !addr_trap_irq)
    else $error("event without fetch");
  irq_hold_a: assert property (!instr_last_cycle |=> $stable(irq_request))
    else $error("request moved early");
endmodule

bind eits_core eits_core_sva i_eits_core_sva (
  .pclk(pclk), .presetn(presetn), .single_chip(single_chip), .instr_last_cycle(instr_last_cycle),
  .fetch(fetch), .accept(accept), .maskable_return_op(maskable_return_op),
  .nonmaskable_return_op(nonmaskable_return_op), .ret(ret), .fetch_opcode(fetch_opcode),
  .irq_request(irq_request), .soft_irq(soft_irq), .undefined_op_irq(undefined_op_irq),
  .addr_trap_irq(addr_trap_irq), .trap_reset_out(trap_reset_out), .master_irq_enable(master_irq_enable)
);

// >>> verif/eits_cpu_model.sv
// cpu core and external pin sources facing the interrupt source block
// assumes its tasks are entered just after a rising pclk edge
`timescale 1ns/1ps
module eits_cpu_model (
  input  wire logic              pclk,
  output eits_pkg::eits_fetch_t  fetch,
  output eits_pkg::eits_accept_t accept,
  output logic                   maskable_return_op,
  output logic                   nonmaskable_return_op,
  output logic                   instr_last_cycle,
  output logic [5:0]             ext_pin,
  output logic                   low_clock_tick
);
  logic [1:0] tick_cnt;
  // pins idle high as with pull-ups
  initial
  begin
    fetch = '0;
    accept = '0;
    maskable_return_op = 1'b0;
    nonmaskable_return_op = 1'b0;
    instr_last_cycle = 1'b0;
    ext_pin = 6'h3F;
    low_clock_tick = 1'b0;
    tick_cnt = 2'h0;
  end
  // low clock runs free at a quarter of pclk
  always @(posedge pclk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    low_clock_tick <= (tick_cnt == 2'h3);
  end
  // released buses show inverted data
  task automatic fetch_op(input logic [15:0] a, input logic [7:0] d, input logic ex, input logic un);
    fetch <= {1'b1, a, d, ex, un};
    @(posedge pclk);
    fetch <= {1'b0, ~a, ~d, ~ex, ~un};
    @(posedge pclk);
  endtask
  task automatic accept_irq(input logic [15:0] pc, input logic [7:0] sw);
    accept <= {1'b1, pc, sw};
    @(posedge pclk);
    accept <= {1'b0, ~pc, ~sw};
    @(posedge pclk);
  endtask
  task automatic ret_op(input logic nm);
    nonmaskable_return_op <= nm;
    maskable_return_op <= !nm;
    @(posedge pclk);
    nonmaskable_return_op <= 1'b0;
    maskable_return_op <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic last_cycle;
    instr_last_cycle <= 1'b1;
    @(posedge pclk);
    instr_last_cycle <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pin_pulse(input int ch, input int n);
    ext_pin[ch] <= 1'b0;
    repeat (n) @(posedge pclk);
    ext_pin[ch] <= 1'b1;
    @(posedge pclk);
  endtask
endmodule

// >>> verif/eits_core_tb.sv
// self-checking bench: apb master, cpu model and event scoreboard
// assumes the cpu model drives fetch, stack and pin activity
`timescale 1ns/1ps
`include "eits_params.svh"
module eits_core_tb;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic                   single_chip = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata, rd;
  logic                   pready, pslverr, rd_err, irq_request, soft_irq, undefined_op_irq;
  logic                   addr_trap_irq, trap_reset_out, port_zero_bit_zero, master_irq_enable;
  logic                   low_clock_tick, instr_last_cycle, maskable_return_op, nonmaskable_return_op;
  logic [7:0]             fetch_opcode;
  logic [5:0]             ext_pin;
  eits_pkg::eits_fetch_t  fetch;
  eits_pkg::eits_accept_t accept;
  eits_pkg::eits_return_t ret;
  logic [39:0]            expq[$];
  int                     n_errors = 0;
  int                     compares = 0;
  int                     cyc = 0;
  logic [31:0] cases [9] = '{32'h0010_1292, 32'h0100_12C1, 32'h0F80_FF92, 32'h023F_5A81, 32'h0240_FF88,
                             32'h4000_1228, 32'h4000_5AC4, 32'h4000_3400, 32'h0F7F_0080};
  int shortp [7] = '{1, 14, 6, 6, 6, 1, 2};
  int longp [7] = '{11, 53, 29, 29, 29, 11, 24};

  always #4 pclk = ~pclk;

  eits_core #(.CNT_W(8)) i_eits_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin),
    .low_clock_tick(low_clock_tick), .serial_tx_irq(1'b0), .adc_irq(1'b0), .latch_ack(6'h00),
    .single_chip(single_chip), .instr_last_cycle(instr_last_cycle), .fetch(fetch), .accept(accept),
    .maskable_return_op(maskable_return_op), .nonmaskable_return_op(nonmaskable_return_op), .ret(ret),
    .fetch_opcode(fetch_opcode), .irq_request(irq_request), .soft_irq(soft_irq),
    .undefined_op_irq(undefined_op_irq), .addr_trap_irq(addr_trap_irq), .trap_reset_out(trap_reset_out),
    .port_zero_bit_zero(port_zero_bit_zero), .master_irq_enable(master_irq_enable)
  );
  eits_cpu_model i_eits_cpu_model (
    .pclk(pclk), .fetch(fetch), .accept(accept), .maskable_return_op(maskable_return_op),
    .nonmaskable_return_op(nonmaskable_return_op), .instr_last_cycle(instr_last_cycle),
    .ext_pin(ext_pin), .low_clock_tick(low_clock_tick)
  );

  task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // trailing idle cycle avoids double driving
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  task automatic ev(input logic [4:0] f, input logic [7:0] op, input logic [15:0] pc, input logic [7:0] sw);
    expq.push_back({f, 3'b0, op, pc, sw});
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      report_and_stop;
    end
  end
  // each event pulse takes the oldest note
  always @(posedge pclk)
    if (presetn && (ret.valid | soft_irq | undefined_op_irq | addr_trap_irq | trap_reset_out))
      check("event", {ret.valid, soft_irq, undefined_op_irq, addr_trap_irq, trap_reset_out, 3'b0,
                      ret.valid ? 8'h00 : fetch_opcode, ret.valid ? {ret.pc, ret.status_word} : 24'h0},
            expq.size() ? expq.pop_front() : 40'h0);

  initial
  begin
    logic [31:0] c;
    logic [15:0] pc;
    logic [7:0] sw;
    int ch;
    void'($urandom(32'h7A99));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("control", `EITS_OFS_CONTROL, 32'h0);
    rchk("stack", `EITS_OFS_STACKPTR, 32'hFF);
    apb(1'b0, 8'h1C, 32'h0);
    check("unmapped", {rd_err, rd}, {1'b1, 32'h0});
    apb(1'b1, `EITS_OFS_CONTROL, 32'h18);
    repeat (40) @(posedge pclk);
    rchk("level after reset", `EITS_OFS_LATCH, 32'h3F00);
    for (int i = 0; i < 9; i++)
    begin
      c = cases[i];
      single_chip <= c[5];
      apb(1'b1, `EITS_OFS_WATCHDOG, {31'h0, c[4]});
      if (c[3:0] != 4'h0)
        ev({1'b0, c[3:0]}, (c[5] && !c[7]) ? 8'hFF : c[15:8], 16'h0, 8'h0);
      i_eits_cpu_model.fetch_op(c[31:16], c[15:8], c[7], c[6]);
    end
    single_chip <= 1'b0;
    repeat (20) i_eits_cpu_model.fetch_op(16'h1000 + 16'($urandom_range(0, 32'hEFFF)),
                                          8'($urandom_range(0, 32'hFE)), 1'b1, 1'b0);
    apb(1'b1, `EITS_OFS_WATCHDOG, 32'h1);
    apb(1'b1, `EITS_OFS_ENABLE, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      pc = `EITS_RAM_BASE + 16'($urandom_range(0, 32'h1FF));
      sw = 8'($urandom) | 8'h01;
      i_eits_cpu_model.accept_irq(pc, sw);
      rchk("sp push", `EITS_OFS_STACKPTR, 32'hFC);
      ev(5'h10, 8'h00, pc, sw);
      i_eits_cpu_model.ret_op(i[0]);
      check("master", master_irq_enable, 1'b1);
      rchk("sp pop", `EITS_OFS_STACKPTR, 32'hFF);
      ev(5'h02, 8'h12, 16'h0, 8'h0);
      i_eits_cpu_model.fetch_op(pc, 8'h12, 1'b1, 1'b0);
    end
    i_eits_cpu_model.accept_irq(16'h0100, 8'h01);
    check("master clear", master_irq_enable, 1'b0);
    apb(1'b1, `EITS_OFS_STACKPTR, 32'hFF);
    rchk("sp restart", `EITS_OFS_STACKPTR, 32'hFF);
    apb(1'b1, `EITS_OFS_CONTROL, 32'h0B);
    i_eits_cpu_model.pin_pulse(0, 11);
    repeat (40) @(posedge pclk);
    rchk("pin zero off", `EITS_OFS_LATCH, 32'h3F00);
    apb(1'b1, `EITS_OFS_CONTROL, 32'h4B);
    for (int k = 0; k < 7; k++)
    begin
      ch = (k == 6) ? 2 : k;
      apb(1'b1, `EITS_OFS_MODE, (k == 6) ? 32'h1 : 32'h0);
      i_eits_cpu_model.pin_pulse(ch, shortp[k]);
      repeat (60) @(posedge pclk);
      rchk("short pulse", `EITS_OFS_LATCH, 32'h3F00);
      i_eits_cpu_model.pin_pulse(ch, longp[k]);
      repeat (2 * longp[k] + 10) @(posedge pclk);
      rchk("long pulse", `EITS_OFS_LATCH, 32'h3F00 | (32'h1 << ch));
      apb(1'b1, `EITS_OFS_LATCH, 32'h3F);
    end
    apb(1'b1, `EITS_OFS_MODE, 32'h0);
    i_eits_cpu_model.pin_pulse(2, 29);
    repeat (70) @(posedge pclk);
    apb(1'b1, `EITS_OFS_ENABLE, 32'h0101);
    check("no sample", irq_request, 1'b0);
    i_eits_cpu_model.last_cycle();
    check("sampled", irq_request, 1'b1);
    apb(1'b1, `EITS_OFS_ENABLE, 32'h0);
    check("port bit", port_zero_bit_zero, 1'b1);
    check("pending", 40'(expq.size()), 40'h0);
    report_and_stop;
  end
endmodule
